/* hdl/usbte_buf.sv */
// Byte buffer for received setup and OUT payloads, registered read port.
module usbte_buf (
    // Clock
    input  wire logic                         clk,
    input  wire logic                         ce,
    // Write side
    input  wire logic                         wr_en,
    input  wire logic [usbte_pkg::BUF_AW-1:0] wr_addr,
    input  wire logic [7:0]                   wr_data,
    // Read side
    input  wire logic [usbte_pkg::BUF_AW-1:0] rd_addr,
    output logic      [7:0]                   rd_data
);
    import usbte_pkg::*;

    logic [7:0] mem [0:(1<<BUF_AW)-1];

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

/* hdl/usbte_engine.sv */
// Device-side USB transaction engine: handshakes, toggles, control stages.
module usbte_engine (
    // Clock, reset and enable
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // Decoded receive byte stream
    input  wire usbte_pkg::usbte_rx_s         rx,
    // Transmit request and completion
    output usbte_pkg::usbte_tx_s              tx,
    input  wire logic                         tx_done,
    // Device configuration
    input  wire logic [6:0]                   dev_addr,
    input  wire logic                         low_speed,
    input  wire usbte_pkg::usbte_ep_e         ep_type [usbte_pkg::NUM_EP],
    // Endpoint readiness from the application
    input  wire logic [usbte_pkg::NUM_EP-1:0] in_ready,
    input  wire logic [usbte_pkg::LEN_W-1:0]  in_len [usbte_pkg::NUM_EP],
    input  wire logic [usbte_pkg::NUM_EP-1:0] out_room,
    input  wire logic [usbte_pkg::NUM_EP-1:0] halt,
    // Events and state
    output usbte_pkg::usbte_ev_s              ev,
    output usbte_pkg::usbte_ctl_e             ctl_stage,
    // Payload buffer read port
    input  wire logic [usbte_pkg::BUF_AW-1:0] rd_addr,
    output logic      [7:0]                   rd_data
);
    import usbte_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DATA,
        ST_IN_RESP,
        ST_TX,
        ST_WAIT_HS
    } usbte_st_e;

    usbte_st_e        state;
    logic [LEN_W-1:0] rx_cnt;
    logic [7:0]       pid_byte;
    logic [7:0]       byte1;
    logic [7:0]       byte2;
    logic             setup_dir_in;
    logic             setup_wlen_nz;
    logic [3:0]       tok_pid;
    logic [1:0]       tok_ep;
    logic             tok_ep_ok;
    logic [NUM_EP-1:0] in_tog;
    logic [NUM_EP-1:0] out_tog;
    logic             hs_expected;
    logic [TMR_W-1:0] tmr;
    logic             in_wait;

    logic             pid_good;
    logic [3:0]       pid;
    logic [LEN_W-1:0] pay_len;
    logic             tok_match;
    usbte_ep_e        cur_type;
    logic             wr_en;

    // Largest payload that an endpoint of the given kind may carry.
    function automatic logic [LEN_W-1:0] max_len(usbte_ep_e t, logic ls);
        case (t)
            EP_ISO:  max_len = ISO_MAX;
            EP_INT:  max_len = ls ? INT_MAX_LS : INT_MAX_FS;
            EP_BULK: max_len = BULK_MAX;
            default: max_len = CTRL_MAX;
        endcase
    endfunction

    function automatic logic [3:0] data_pid(logic tog);
        data_pid = tog ? PID_DATA1 : PID_DATA0;
    endfunction

    // Bulk and isochronous kinds do not exist on a low-speed device.
    function automatic logic kind_banned(usbte_ep_e t, logic ls);
        kind_banned = ls && (t == EP_BULK || t == EP_ISO);
    endfunction

    assign pid       = pid_byte[3:0];
    assign pid_good  = (pid_byte[7:4] == ~pid_byte[3:0]);
    assign pay_len   = (rx_cnt > CRC_BYTES + 11'h001) ?
                       rx_cnt - CRC_BYTES - 11'h001 : '0;
    assign tok_match = (byte1[6:0] == dev_addr);
    assign cur_type  = ep_type[tok_ep];
    assign wr_en     = rx.valid && rx_cnt != '0 && rx_cnt <= ISO_MAX + 11'h002;

    // Packet capture: PID, token fields and setup command fields.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_cnt        <= '0;
            pid_byte      <= '0;
            byte1         <= '0;
            byte2         <= '0;
            setup_dir_in  <= 1'b0;
            setup_wlen_nz <= 1'b0;
        end else if (ce) begin
            if (rx.start) begin
                rx_cnt        <= '0;
                setup_wlen_nz <= 1'b0;
            end else if (rx.valid) begin
                if (rx_cnt != ISO_MAX + 11'h003) begin
                    rx_cnt <= rx_cnt + 11'h001;
                end
                case (rx_cnt)
                    11'h000: pid_byte <= rx.data;
                    11'h001: begin
                        byte1        <= rx.data;
                        setup_dir_in <= rx.data[7];
                    end
                    11'h002: byte2 <= rx.data;
                    11'h007, 11'h008: begin
                        if (rx.data != 8'h00) begin
                            setup_wlen_nz <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Transaction sequencer and handshake choice.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state       <= ST_IDLE;
            tok_pid     <= '0;
            tok_ep      <= '0;
            tok_ep_ok   <= 1'b0;
            tx          <= '0;
            hs_expected <= 1'b0;
        end else if (ce) begin
            tx.req <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Preamble and SOF need no action here; a device on
                    // the full-speed side simply lets them pass.
                    if (rx.eop && pid_good && rx.crc_ok && rx_cnt >= 11'h003
                        && (pid == PID_OUT || pid == PID_IN
                            || pid == PID_SETUP) && tok_match) begin
                        tok_pid   <= pid;
                        tok_ep    <= {byte2[0], byte1[7]};
                        tok_ep_ok <= byte2[2:1] == 2'b00;
                        state     <= (pid == PID_IN) ? ST_IN_RESP : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx.eop) begin
                        state <= ST_IDLE;
                        // Corrupt or non-data packets end the transaction
                        // silently; the host retries.
                        if (pid_good && rx.crc_ok && tok_ep_ok
                            && (pid == PID_DATA0 || pid == PID_DATA1)) begin
                            if (tok_pid == PID_SETUP) begin
                                if (pid == PID_DATA0 && pay_len == SETUP_LEN
                                    && cur_type == EP_CTRL) begin
                                    tx.req <= 1'b1;
                                    tx.pid <= PID_ACK;
                                    tx.ep  <= tok_ep;
                                    tx.len <= '0;
                                    state  <= ST_TX;
                                end
                            end else if (cur_type == EP_ISO) begin
                                // No handshake on isochronous data.
                                state <= ST_IDLE;
                            end else if (pay_len > max_len(cur_type,
                                                           low_speed)) begin
                                state <= ST_IDLE;
                            end else begin
                                tx.req <= 1'b1;
                                tx.len <= '0;
                                tx.ep  <= tok_ep;
                                state  <= ST_TX;
                                if (halt[tok_ep]
                                    || kind_banned(cur_type, low_speed)) begin
                                    tx.pid <= PID_STALL;
                                end else if (ctl_stage == CS_DATA_OUT
                                             || ctl_stage == CS_STATUS_OUT
                                             || cur_type != EP_CTRL) begin
                                    tx.pid <= (out_room[tok_ep]
                                               || ctl_stage == CS_STATUS_OUT)
                                              ? PID_ACK : PID_NAK;
                                end else begin
                                    tx.pid <= PID_STALL;
                                end
                            end
                        end
                    end else if (rx.start && rx_cnt != '0 && !rx.valid
                                 && 1'b0) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IN_RESP: begin
                    tx.req      <= 1'b1;
                    tx.ep       <= tok_ep;
                    hs_expected <= 1'b0;
                    state       <= ST_TX;
                    if (!tok_ep_ok || halt[tok_ep]
                        || kind_banned(cur_type, low_speed)
                        || (cur_type == EP_CTRL && (ctl_stage == CS_IDLE
                            || ctl_stage == CS_STATUS_OUT))) begin
                        tx.pid <= PID_STALL;
                        tx.len <= '0;
                    end else if (cur_type == EP_CTRL
                                 && ctl_stage == CS_STATUS_IN) begin
                        tx.pid      <= PID_DATA1;
                        tx.len      <= '0;
                        hs_expected <= 1'b1;
                    end else if (!in_ready[tok_ep]) begin
                        tx.pid <= PID_NAK;
                        tx.len <= '0;
                        tx.req <= cur_type != EP_ISO;
                        state  <= (cur_type == EP_ISO) ? ST_IDLE : ST_TX;
                    end else begin
                        tx.pid <= (cur_type == EP_ISO) ? PID_DATA0
                                  : data_pid(in_tog[tok_ep]);
                        tx.len <= (in_len[tok_ep] > max_len(cur_type,
                                                            low_speed))
                                  ? max_len(cur_type, low_speed)
                                  : in_len[tok_ep];
                        hs_expected <= cur_type != EP_ISO;
                    end
                end
                ST_TX: begin
                    if (tx_done) begin
                        state <= hs_expected ? ST_WAIT_HS : ST_IDLE;
                    end
                end
                ST_WAIT_HS: begin
                    if (rx.eop || tmr == TMR_W'(TIMEOUT_CYC)) begin
                        state       <= ST_IDLE;
                        hs_expected <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Handshake timer; it stops once a reply packet begins to arrive.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr     <= '0;
            in_wait <= 1'b0;
        end else if (ce) begin
            if (state != ST_WAIT_HS) begin
                tmr     <= '0;
                in_wait <= 1'b0;
            end else if (rx.start) begin
                in_wait <= 1'b1;
            end else if (!in_wait && tmr != TMR_W'(TIMEOUT_CYC)) begin
                tmr <= tmr + TMR_W'(1);
            end
        end
    end

    // Data toggles per endpoint and direction.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_tog  <= '0;
            out_tog <= '0;
        end else if (ce) begin
            if (state == ST_DATA && rx.eop && pid_good && rx.crc_ok
                && tok_pid == PID_SETUP && pid == PID_DATA0
                && pay_len == SETUP_LEN) begin
                in_tog[tok_ep]  <= 1'b1;
                out_tog[tok_ep] <= 1'b1;
            end else if (state == ST_TX && tx_done && tx.pid == PID_ACK
                         && tok_pid == PID_OUT) begin
                out_tog[tok_ep] <= ~out_tog[tok_ep];
            end else if (state == ST_WAIT_HS && rx.eop && pid_good
                         && pid == PID_ACK) begin
                in_tog[tok_ep] <= ~in_tog[tok_ep];
            end
        end
    end

    // Control transfer stage tracking on endpoint zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_stage <= CS_IDLE;
        end else if (ce) begin
            if (state == ST_DATA && rx.eop && pid_good && rx.crc_ok
                && tok_pid == PID_SETUP && pid == PID_DATA0
                && pay_len == SETUP_LEN) begin
                if (!setup_wlen_nz) begin
                    ctl_stage <= CS_STATUS_IN;
                end else begin
                    ctl_stage <= setup_dir_in ? CS_DATA_IN
                                              : CS_DATA_OUT;
                end
            end else if (state == ST_IDLE && rx.eop && pid_good
                         && tok_match && byte2[2:0] == 3'b000
                         && !byte1[7]) begin
                // An opposite token ends the data stage, early or not.
                if (ctl_stage == CS_DATA_IN && pid == PID_OUT) begin
                    ctl_stage <= CS_STATUS_OUT;
                end else if (ctl_stage == CS_DATA_OUT && pid == PID_IN) begin
                    ctl_stage <= CS_STATUS_IN;
                end
            end else if (tok_ep == 2'd0 && ((state == ST_WAIT_HS && rx.eop
                         && pid_good && pid == PID_ACK
                         && ctl_stage == CS_STATUS_IN)
                         || (state == ST_TX && tx_done && tx.pid == PID_ACK
                         && ctl_stage == CS_STATUS_OUT))) begin
                ctl_stage <= CS_IDLE;
            end
        end
    end

    // One-cycle events toward the application.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev <= '0;
        end else if (ce) begin
            ev.setup_rx <= state == ST_TX && tx_done && tok_pid == PID_SETUP;
            ev.out_rx   <= (state == ST_TX && tx_done && tx.pid == PID_ACK
                            && tok_pid == PID_OUT)
                           || (state == ST_DATA && rx.eop && pid_good
                               && rx.crc_ok && cur_type == EP_ISO
                               && tok_pid == PID_OUT && pid == PID_DATA0
                               && pay_len <= ISO_MAX);
            ev.in_acked <= state == ST_WAIT_HS && rx.eop && pid_good
                           && pid == PID_ACK;
            // A short packet marks the end of the IN data.
            ev.in_last  <= state == ST_WAIT_HS && rx.eop && pid_good
                           && pid == PID_ACK
                           && tx.len < max_len(cur_type, low_speed);
            ev.timeout  <= state == ST_WAIT_HS && !in_wait
                           && tmr == TMR_W'(TIMEOUT_CYC);
            ev.ctl_done <= ctl_stage != CS_IDLE && tok_ep == 2'd0
                           && state == ST_WAIT_HS && rx.eop && pid_good
                           && pid == PID_ACK && ctl_stage == CS_STATUS_IN;
            if (state == ST_DATA && rx.eop) begin
                ev.ep  <= tok_ep;
                ev.len <= pay_len;
            end
        end
    end

    usbte_buf u_buf (
        .clk     (clk),
        .ce      (ce),
        .wr_en   (wr_en && state == ST_DATA),
        .wr_addr (BUF_AW'(rx_cnt - 11'h001)),
        .wr_data (rx.data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );
endmodule

/* hdl/usbte_pkg.sv */
// Package with constants and types for the USB device transaction engine.
// Notes on behaviour
// - Answer STALL when the endpoint is halted and needs host intervention.
// - A packet with bad PID or CRC gets no handshake at all.
// - No answer within 16 to 18 bit times after sending data is a timeout.
// - Setup data packet is exactly 8 bytes and always DATA0.
// - Setup transactions are always acknowledged, never NAK or STALL.
// - All packets of one control data stage move in one direction.
// - An IN data stage ends with a short or zero-length packet.
// - Control data stage packets toggle, starting with DATA1.
// - First token opposite to the data or setup direction starts status.
// - The status stage data packet is zero bytes and DATA1.
// - Host may end a data stage early; device then moves to status.
// - Bulk data errors get no handshake; unacknowledged data is resent.
// - Bulk answers NAK when not ready; no bulk on low-speed devices.
// - Bulk IN is acknowledged by host, bulk OUT by the device.
// - Bulk data packets toggle DATA0, DATA1, DATA0 in each direction.
// - Isochronous traffic may come back to back across frame boundaries.
// - Isochronous has no handshake, no resend, and no low-speed use; halted or low-speed iso IN still gets STALL.
// - Isochronous packets are at most 1023 bytes and always DATA0.
// - Interrupt packets are at most 64 bytes full speed, 8 low speed.
// - Interrupt IN without data gets NAK; interrupt OUT gets ACK or NAK.
// - PID field must match the complement field, otherwise PID error.
package usbte_pkg;
    localparam int NUM_EP = 4;
    localparam int BUF_AW = 10;
    localparam int LEN_W  = 11;

    localparam logic [3:0] PID_OUT   = 4'h1;
    localparam logic [3:0] PID_IN    = 4'h9;
    localparam logic [3:0] PID_SOF   = 4'h5;
    localparam logic [3:0] PID_SETUP = 4'hD;
    localparam logic [3:0] PID_DATA0 = 4'h3;
    localparam logic [3:0] PID_DATA1 = 4'hB;
    localparam logic [3:0] PID_ACK   = 4'h2;
    localparam logic [3:0] PID_NAK   = 4'hA;
    localparam logic [3:0] PID_STALL = 4'hE;
    localparam logic [3:0] PID_PRE   = 4'hC;

    localparam logic [LEN_W-1:0] SETUP_LEN  = 11'h008;
    localparam logic [LEN_W-1:0] CTRL_MAX   = 11'h040;
    localparam logic [LEN_W-1:0] BULK_MAX   = 11'h040;
    localparam logic [LEN_W-1:0] ISO_MAX    = 11'h3FF;
    localparam logic [LEN_W-1:0] INT_MAX_FS = 11'h040;
    localparam logic [LEN_W-1:0] INT_MAX_LS = 11'h008;
    localparam logic [LEN_W-1:0] CRC_BYTES  = 11'h002;

    // Timeout is the longest allowed wait, rounded down to whole cycles.
    localparam int CLK_PS       = 5000;
    localparam int BIT_TIME_PS  = 83333;
    localparam int TIMEOUT_BITS = 18;
    localparam int TIMEOUT_CYC  = (TIMEOUT_BITS * BIT_TIME_PS) / CLK_PS;
    localparam int TMR_W        = 9;

    typedef enum logic [1:0] {
        EP_CTRL,
        EP_ISO,
        EP_BULK,
        EP_INT
    } usbte_ep_e;

    typedef enum logic [2:0] {
        CS_IDLE,
        CS_DATA_IN,
        CS_DATA_OUT,
        CS_STATUS_IN,
        CS_STATUS_OUT
    } usbte_ctl_e;

    typedef struct packed {
        logic       start;
        logic       valid;
        logic [7:0] data;
        logic       eop;
        logic       crc_ok;
    } usbte_rx_s;

    typedef struct packed {
        logic             req;
        logic [3:0]       pid;
        logic [LEN_W-1:0] len;
        logic [1:0]       ep;
    } usbte_tx_s;

    typedef struct packed {
        logic             setup_rx;
        logic             out_rx;
        logic [1:0]       ep;
        logic [LEN_W-1:0] len;
        logic             in_acked;
        logic             in_last;
        logic             timeout;
        logic             ctl_done;
    } usbte_ev_s;
endpackage

/* tb/usbte_asserts.sv */
// Checker for the engine's answers at its ports.
module usbte_asserts (
    // Link
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire usbte_pkg::usbte_rx_s         rx,
    input wire usbte_pkg::usbte_tx_s         tx,
    input wire logic                         tx_done,
    // Configuration and events
    input wire logic                         low_speed,
    input wire usbte_pkg::usbte_ep_e         ep_type [usbte_pkg::NUM_EP],
    input wire logic [usbte_pkg::NUM_EP-1:0] halt,
    input wire usbte_pkg::usbte_ev_s         ev
);
    timeunit 1ns;
    timeprecision 100ps;
    import usbte_pkg::*;
    logic [7:0] pid_byte;
    logic       first;
    int         gap;
    wire        pid_bad = pid_byte[7:4] != ~pid_byte[3:0];
    wire        iso = ep_type[tx.ep] == EP_ISO;
    always_ff @(posedge clk) first <= rx.start | (first & ~rx.valid);
    always_ff @(posedge clk) if (rx.valid && first) pid_byte <= rx.data;
    // Idle time since the last packet went out or began to arrive, for the timeout window.
    always_ff @(posedge clk) gap <= (!rst_n || tx_done || rx.start) ? 0 : gap + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_setup_acked: assert property (
        ev.setup_rx |-> ##[0:2] tx.pid == PID_ACK) else $error("setup not acked");
    a_bad_pid_quiet: assert property (
        rx.eop && pid_bad |-> ##1 !tx.req [*3]) else $error("answer to bad pid");
    a_bad_crc_quiet: assert property (
        rx.eop && !rx.crc_ok |-> ##1 !tx.req [*3]) else $error("answer to bad crc");
    a_iso_data0: assert property (
        tx.req && iso && !low_speed |-> tx.pid == PID_DATA0) else $error("iso pid");
    a_iso_size: assert property (
        tx.req && iso |-> tx.len <= ISO_MAX) else $error("iso too long");
    a_halt_stall: assert property (
        tx.req && halt[tx.ep] && ep_type[tx.ep] == EP_BULK |-> tx.pid == PID_STALL)
        else $error("halted without stall");
    a_ls_refused: assert property (
        tx.req && low_speed && ep_type[tx.ep] inside {EP_BULK, EP_ISO}
        |-> tx.pid == PID_STALL) else $error("low speed bulk or iso");
    a_timeout_window: assert property (
        ev.timeout |-> gap >= 266 && gap <= 301) else $error("timeout moment");
    c_setup: cover property (ev.setup_rx);
    c_timeout: cover property (ev.timeout);
    c_stall: cover property (tx.req && tx.pid == PID_STALL);
endmodule
bind usbte_engine usbte_asserts i_chk (.clk, .rst_n, .rx, .tx, .tx_done,
    .low_speed, .ep_type, .halt, .ev);

/* tb/usbte_engine_test.sv */
// Self-checking bench for the USB device transaction engine.
module usbte_engine_test;
    timeunit 1ns;
    timeprecision 100ps;
    import usbte_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              ls = 1'b0;
    usbte_rx_s         rx;
    usbte_tx_s         tx;
    logic              tx_done;
    usbte_ev_s         ev;
    usbte_ctl_e        ctl_stage;
    logic [NUM_EP-1:0] rdy = '0;
    logic [NUM_EP-1:0] room = '1;
    logic [NUM_EP-1:0] halt = '0;
    logic [LEN_W-1:0]  in_len [NUM_EP] = '{default: 11'h008};
    usbte_ep_e         ep_type [NUM_EP] = '{EP_CTRL, EP_ISO, EP_BULK, EP_INT};
    logic [BUF_AW-1:0] rd_addr = '0;
    logic [7:0]        rd_data;
    int                error_cnt = 0;
    int                n_compared = 0;
    always #2.5 clk = ~clk;
    usbte_engine i_dut (.clk, .rst_n, .ce(1'b1), .rx, .tx, .tx_done,
        .dev_addr(7'h05), .low_speed(ls), .ep_type, .in_ready(rdy), .in_len,
        .out_room(room), .halt, .ev, .ctl_stage, .rd_addr, .rd_data);
    usbte_host i_host (.clk, .rx, .tx, .tx_done);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tok(input logic [3:0] p, input logic [1:0] ep);
        i_host.send('{{~p, p}, {ep[0], 7'h05}, {7'h00, ep[1]}}, 1'b1);
    endtask
    task automatic dat(input logic [3:0] p, input int n, input logic ok);
        logic [7:0] q [$];
        q = '{{~p, p}};
        for (int i = 0; i < n + 2; i++) q.push_back(8'(i));
        i_host.send(q, ok);
    endtask
    // A pid of zero means that no answer at all may come.
    task automatic ans(input logic [3:0] p);
        int n0;
        n0 = i_host.n_req;
        repeat (12) @(negedge clk);
        chk(16'(i_host.n_req - n0), (p == 4'h0) ? 16'h0000 : 16'h0001);
        if (p != 4'h0) chk(16'(i_host.last_pid), 16'(p));
        repeat (8) @(negedge clk);
    endtask
    task automatic hs();
        i_host.send('{8'hD2}, 1'b1);
        repeat (3) @(negedge clk);
    endtask
    task automatic t_setup();
        halt[0] = 1'b1;
        tok(PID_SETUP, 2'd0);
        i_host.send('{8'hC3, 8'h80, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00,
            8'h20, 8'h00, 8'h00, 8'h00}, 1'b1);
        ans(PID_ACK);
        rd_addr = 10'h003;
        repeat (2) @(negedge clk);
        chk(16'(rd_data), 16'h0001);
        chk(16'(ctl_stage), 16'(CS_DATA_IN));
        halt[0] = 1'b0;
    endtask
    task automatic t_ctrl();
        rdy[0] = 1'b1;
        for (int i = 0; i < 2; i++) begin
            tok(PID_IN, 2'd0);
            ans((i != 0) ? PID_DATA0 : PID_DATA1);
            chk(16'(i_host.last_len), 16'h0008);
            hs();
        end
        tok(PID_OUT, 2'd0);
        dat(PID_DATA1, 0, 1'b1);
        ans(PID_ACK);
    endtask
    task automatic t_bad();
        i_host.send('{8'h11, 8'h05, 8'h01}, 1'b1);
        ans(4'h0);
        i_host.send('{8'h3C}, 1'b1);
        ans(4'h0);
        tok(PID_OUT, 2'd2);
        dat(PID_DATA0, 4, 1'b0);
        ans(4'h0);
    endtask
    task automatic t_bulk();
        room[2] = 1'b0;
        tok(PID_OUT, 2'd2);
        dat(PID_DATA0, 4, 1'b1);
        ans(PID_NAK);
        tok(PID_IN, 2'd2);
        ans(PID_NAK);
        rdy[2] = 1'b1;
        i_host.dly = 12;
        tok(PID_IN, 2'd2);
        ans(PID_DATA0);
        hs();
        tok(PID_IN, 2'd2);
        ans(PID_DATA1);
        for (int k = 0; k < 320 && ev.timeout !== 1'b1; k++) @(negedge clk);
        chk(16'(ev.timeout), 16'h0001);
        tok(PID_IN, 2'd2);
        ans(PID_DATA1);
        hs();
        i_host.dly = 4;
        halt[2] = 1'b1;
        tok(PID_IN, 2'd2);
        ans(PID_STALL);
        halt[2] = 1'b0;
    endtask
    task automatic t_iso();
        rdy[1] = 1'b1;
        repeat (2) begin
            tok(PID_IN, 2'd1);
            ans(PID_DATA0);
        end
        tok(PID_OUT, 2'd1);
        dat(PID_DATA0, 4, 1'b1);
        ans(4'h0);
    endtask
    task automatic t_int();
        tok(PID_IN, 2'd3);
        ans(PID_NAK);
        tok(PID_OUT, 2'd3);
        dat(PID_DATA0, 4, 1'b1);
        ans(PID_ACK);
        room[3] = 1'b0;
        tok(PID_OUT, 2'd3);
        dat(PID_DATA1, 4, 1'b1);
        ans(PID_NAK);
    endtask
    task automatic t_ls();
        ls = 1'b1;
        for (int e = 1; e < 3; e++) begin
            tok(PID_IN, 2'(e));
            ans(PID_STALL);
        end
        ls = 1'b0;
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_setup();
        t_ctrl();
        t_bad();
        t_bulk();
        t_iso();
        t_int();
        t_ls();
        complete_run();
    end
    initial begin
        #100us;
        error_cnt++;
        complete_run();
    end
endmodule

/* tb/usbte_host.sv */
// Host model: frames packets to the engine and serializes its answers.
module usbte_host (
    // Clock
    input  wire logic                 clk,
    // Link towards the engine
    output usbte_pkg::usbte_rx_s      rx,
    input  wire usbte_pkg::usbte_tx_s tx,
    output logic                      tx_done
);
    timeunit 1ns;
    timeprecision 100ps;
    import usbte_pkg::*;
    int               n_req = 0;
    int               dly = 4;
    logic [3:0]       last_pid;
    logic [LEN_W-1:0] last_len;
    initial begin
        rx = '0;
        tx_done = 1'b0;
    end
    // A slow shifter is modelled by a larger dly; answers are never dropped.
    always @(negedge clk) begin
        if (tx.req === 1'b1) begin
            last_pid = tx.pid;
            last_len = tx.len;
            n_req++;
            repeat (dly) @(negedge clk);
            tx_done = 1'b1;
            @(negedge clk);
            tx_done = 1'b0;
        end
    end
    task automatic send(input logic [7:0] b [$], input logic ok);
        @(negedge clk);
        rx.start = 1'b1;
        foreach (b[i]) begin
            @(negedge clk);
            rx.start = 1'b0;
            rx.valid = 1'b1;
            rx.data = b[i];
        end
        @(negedge clk);
        rx.valid = 1'b0;
        rx.data = ~rx.data;
        rx.eop = 1'b1;
        rx.crc_ok = ok;
        @(negedge clk);
        rx.eop = 1'b0;
    endtask
endmodule
